// [hw/cpu_timing_map.svh]
`ifndef CPU_TIMING_MAP_SVH
`define CPU_TIMING_MAP_SVH

// ****************************************
// Widths
// ****************************************
`define OPC_W 8
`define PC_W 16
`define CNT_W 4
`define LEN_W 2
`define BANK_W 2
`define RD_TIMING_W 2

// ****************************************
// Instruction lengths in bytes
// ****************************************
`define LEN_1 2'h1
`define LEN_2 2'h2
`define LEN_3 2'h3

// ****************************************
// Cycle counts with prefetch on
// ****************************************
`define CYC_1 4'h1
`define CYC_2 4'h2
`define CYC_3 4'h3
`define CYC_IND_CMP 4'h4
`define CYC_MUL 4'h4
`define CYC_SHORT_JMP 4'h4
`define CYC_LONG_JMP 4'h5
`define CYC_RET 4'h6
`define CYC_DIV 4'h8
`define CYC_EXT_MOVE 4'h3
`define BRANCH_EXTRA 4'h2
`define CODE_RD_MIN 4'h4
`define CODE_RD_MAX 4'h7

// ****************************************
// Opcode fields and special codes
// ****************************************
`define OPC_HI 7:4
`define OPC_LO 3:0
`define OPC_RN 2:0
`define OPC_RI 0
`define OPC_PAGE 7:5
`define PC_PAGE 15:11
`define SFR_BIT 7
`define SPARE_OPC 8'ha5
`define BANK_SHIFT 3

`endif

// [hw/cpu_timing_pkg.sv]
package cpu_timing_pkg;

	// Branch condition classes
	typedef enum logic [3:0] {
		BR_NONE, BR_BIT_CLR, BR_BIT, BR_NBIT, BR_CARRY, BR_NCARRY,
		BR_ZERO, BR_NZERO, BR_CMP, BR_DEC_NZ
	} branch_kind_t;

	// Where a branch target comes from
	typedef enum logic [1:0] {
		TGT_NONE, TGT_REL, TGT_ABS11, TGT_ABS16
	} target_kind_t;

	// Sequencer states
	typedef enum logic {
		ST_IDLE, ST_EXEC
	} seq_state_t;

	// Static decode of one opcode
	typedef struct packed {
		logic [1:0] len;
		logic [3:0] cyc;
		branch_kind_t br;
		target_kind_t tgt;
		logic code_rd;
		logic ext;
		logic xwrite;
		logic spare;
	} decode_t;

	// Operand values the branch test needs
	typedef struct packed {
		logic [7:0] acc;
		logic carry;
		logic bit_val;
		logic [7:0] cmp_lhs;
		logic [7:0] cmp_rhs;
	} cond_in_t;

	// Addresses formed from the operand bytes
	typedef struct packed {
		logic [7:0] reg_addr;
		logic [7:0] ind_addr;
		logic [7:0] direct_addr;
		logic direct_is_sfr;
		logic [15:0] rel_target;
		logic [15:0] abs11_target;
		logic [15:0] abs16_target;
	} addr_out_t;

	// Whole state of the timing sequencer
	typedef struct packed {
		seq_state_t st;
		logic [3:0] remain;
		logic busy;
		logic done;
		logic [3:0] cycles;
		logic [1:0] bytes;
		logic taken;
		logic tgt_valid;
		logic [15:0] target;
		logic [7:0] reg_addr;
		logic [7:0] ind_addr;
		logic [7:0] direct_addr;
		logic direct_is_sfr;
		logic ext;
		logic xwrite;
		logic flash_write;
		logic flash_erase;
		logic bit_clear;
		logic spare_nop;
		logic parity;
		logic timing_valid;
	} seq_t;

endpackage : cpu_timing_pkg

// [hw/operand_address_calc.sv]
`timescale 1ns/10ps
`default_nettype none
`include "cpu_timing_map.svh"

// ****************************************
// Operand and branch address forming
// ****************************************
module operand_address_calc (
	input wire logic [7:0] opcode_i,
	input wire logic [7:0] op1_i,
	input wire logic [7:0] op2_i,
	input wire logic [1:0] len_i,
	input wire logic [15:0] next_pc_i,
	input wire logic [1:0] bank_i,
	output cpu_timing_pkg::addr_out_t addr_o
);

	// Rel byte is the last byte of a two- or three-byte instruction (op2 if three bytes, else op1)
	logic [7:0] rel_byte;
	// Bank base address, eight bytes per bank
	logic [7:0] bank_base;

	// Combinational address forming
	always_comb begin
		rel_byte = (len_i == `LEN_3) ? op2_i : op1_i;
		bank_base = 8'({bank_i, 3'h0});
		addr_o.reg_addr = bank_base | 8'(opcode_i[`OPC_RN]);
		// indirect only via R0 or R1
		addr_o.ind_addr = bank_base | 8'(opcode_i[`OPC_RI]);
		addr_o.direct_addr = op1_i;
		addr_o.direct_is_sfr = op1_i[`SFR_BIT];
		addr_o.rel_target = next_pc_i + {{8{rel_byte[7]}}, rel_byte};
		// page bits kept from next address
		addr_o.abs11_target = {next_pc_i[`PC_PAGE], opcode_i[`OPC_PAGE], op1_i};
		addr_o.abs16_target = {op1_i, op2_i};
	end

endmodule : operand_address_calc
`default_nettype wire

// [hw/cpu_instruction_timing.sv]
`timescale 1ns/10ps
`default_nettype none
`include "cpu_timing_map.svh"

module cpu_instruction_timing (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	// Opcode presented by the fetch stage
	input wire logic start_i,
	input wire logic [7:0] opcode_i,
	input wire logic [7:0] op1_i,
	input wire logic [7:0] op2_i,
	input wire logic [15:0] next_pc_i,
	// Core state the decode depends on
	input wire logic [1:0] bank_i,
	input wire cpu_timing_pkg::cond_in_t cond_i,
	// Flash timing controls
	input wire logic prefetch_enable_bit_i,
	input wire logic [1:0] flash_read_timing_field_i,
	input wire logic code_rd_misaligned_i,
	input wire logic flash_write_enable_i,
	input wire logic flash_erase_enable_i,
	// Timing results
	output logic busy_o,
	output logic end_o,
	output logic [3:0] cycle_count_o,
	output logic [1:0] byte_count_o,
	output logic taken_o,
	output logic target_valid_o,
	output logic [15:0] target_o,
	// Operand addresses
	output logic [7:0] reg_addr_o,
	output logic [7:0] ind_addr_o,
	output logic [7:0] direct_addr_o,
	output logic direct_is_sfr_o,
	// External data and flash
	output logic ext_access_o,
	output logic ext_write_o,
	output logic flash_write_o,
	output logic flash_erase_o,
	// Side effects and flags
	output logic bit_clear_o,
	output logic spare_nop_o,
	output logic parity_o,
	output logic timing_valid_o
);

	// ****************************************
	// Opcode decode
	// ****************************************

	function automatic cpu_timing_pkg::decode_t decode_op(input logic [7:0] op);
		cpu_timing_pkg::decode_t d;
		logic [3:0] hi;
		logic [3:0] lo;
		d = '{len: `LEN_1, cyc: `CYC_1, br: cpu_timing_pkg::BR_NONE,
			tgt: cpu_timing_pkg::TGT_NONE, default: 1'b0};
		hi = op[`OPC_HI];
		lo = op[`OPC_LO];
		if (lo[3]) begin
			// Bank register column
			unique case (hi)
				4'h7, 4'h8, 4'ha: begin
					d.len = `LEN_2;
					d.cyc = `CYC_2;
				end
				4'hb: begin
					d.len = `LEN_3;
					d.cyc = `CYC_3;
					d.br = cpu_timing_pkg::BR_CMP;
				end
				4'hd: begin
					d.len = `LEN_2;
					d.cyc = `CYC_2;
					d.br = cpu_timing_pkg::BR_DEC_NZ;
				end
				default: ;
			endcase
		end else if (lo[3:1] == 3'h3) begin
			d.cyc = `CYC_2;
			unique case (hi)
				4'h7, 4'h8, 4'ha: d.len = `LEN_2;
				4'hb: begin
					d.len = `LEN_3;
					d.cyc = `CYC_IND_CMP;
					d.br = cpu_timing_pkg::BR_CMP;
				end
				default: ;
			endcase
		end else if (lo == 4'h5) begin
			// Direct byte column
			d.len = `LEN_2;
			d.cyc = `CYC_2;
			unique case (hi)
				4'h7, 4'h8: begin
					d.len = `LEN_3;
					d.cyc = `CYC_3;
				end
				4'ha: begin
					d.len = `LEN_1;
					d.cyc = `CYC_1;
					d.spare = 1'b1;
				end
				4'hb, 4'hd: begin
					d.len = `LEN_3;
					d.cyc = `CYC_3;
					d.br = (hi == 4'hb) ? cpu_timing_pkg::BR_CMP
						: cpu_timing_pkg::BR_DEC_NZ;
				end
				default: ;
			endcase
		end else if (lo == 4'h4) begin
			// Accumulator and immediate column
			unique case (hi)
				4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9: begin
					d.len = `LEN_2;
					d.cyc = `CYC_2;
				end
				4'h8: d.cyc = `CYC_DIV;
				4'ha: d.cyc = `CYC_MUL;
				4'hb: begin
					d.len = `LEN_3;
					d.cyc = `CYC_3;
					d.br = cpu_timing_pkg::BR_CMP;
				end
				default: ;
			endcase
		end else if (lo == 4'h3) begin
			unique case (hi)
				4'h4, 4'h5, 4'h6: begin
					d.len = `LEN_3;
					d.cyc = `CYC_3;
				end
				4'h7: d.cyc = `CYC_SHORT_JMP;
				4'h8, 4'h9: d.code_rd = 1'b1;
				4'he, 4'hf: begin
					d.cyc = `CYC_EXT_MOVE;
					d.ext = 1'b1;
					d.xwrite = hi[0];
				end
				default: ;
			endcase
		end else if (lo == 4'h2) begin
			unique case (hi)
				4'h0, 4'h1: begin
					d.len = `LEN_3;
					d.cyc = `CYC_LONG_JMP;
					d.tgt = cpu_timing_pkg::TGT_ABS16;
				end
				4'h2, 4'h3: d.cyc = `CYC_RET;
				4'he, 4'hf: begin
					d.cyc = `CYC_EXT_MOVE;
					d.ext = 1'b1;
					d.xwrite = hi[0];
				end
				default: begin
					d.len = `LEN_2;
					d.cyc = `CYC_2;
				end
			endcase
		end else if (lo == 4'h1) begin
			// Page-absolute jump and call
			d.len = `LEN_2;
			d.cyc = `CYC_SHORT_JMP;
			d.tgt = cpu_timing_pkg::TGT_ABS11;
		end else begin
			// Column zero: bit branches, jumps, moves
			unique case (hi)
				4'h0: ;
				4'h1, 4'h2, 4'h3: begin
					d.len = `LEN_3;
					d.cyc = `CYC_3;
					d.br = (hi == 4'h1) ? cpu_timing_pkg::BR_BIT_CLR
						: (hi == 4'h2) ? cpu_timing_pkg::BR_BIT
						: cpu_timing_pkg::BR_NBIT;
				end
				4'h4, 4'h5, 4'h6, 4'h7: begin
					d.len = `LEN_2;
					d.cyc = `CYC_2;
					d.br = (hi == 4'h4) ? cpu_timing_pkg::BR_CARRY
						: (hi == 4'h5) ? cpu_timing_pkg::BR_NCARRY
						: (hi == 4'h6) ? cpu_timing_pkg::BR_ZERO
						: cpu_timing_pkg::BR_NZERO;
				end
				4'h8: begin
					d.len = `LEN_2;
					d.cyc = `CYC_SHORT_JMP;
					d.tgt = cpu_timing_pkg::TGT_REL;
				end
				4'h9: begin
					d.len = `LEN_3;
					d.cyc = `CYC_3;
				end
				4'he, 4'hf: begin
					d.cyc = `CYC_EXT_MOVE;
					d.ext = 1'b1;
					d.xwrite = hi[0];
				end
				default: begin
					d.len = `LEN_2;
					d.cyc = `CYC_2;
				end
			endcase
		end
		// Conditional branches target relative
		if (d.br != cpu_timing_pkg::BR_NONE) begin
			d.tgt = cpu_timing_pkg::TGT_REL;
		end
		return d;
	endfunction : decode_op

	// Branch condition test on datapath values
	function automatic logic branch_true(input cpu_timing_pkg::branch_kind_t br,
		input cpu_timing_pkg::cond_in_t c);
		unique case (br)
			cpu_timing_pkg::BR_BIT_CLR, cpu_timing_pkg::BR_BIT: return c.bit_val;
			cpu_timing_pkg::BR_NBIT: return !c.bit_val;
			cpu_timing_pkg::BR_CARRY: return c.carry;
			cpu_timing_pkg::BR_NCARRY: return !c.carry;
			cpu_timing_pkg::BR_ZERO: return c.acc == 8'h00;
			cpu_timing_pkg::BR_NZERO: return c.acc != 8'h00;
			cpu_timing_pkg::BR_CMP: return c.cmp_lhs != c.cmp_rhs;
			// Source is tested against one, not the decremented value against zero
			cpu_timing_pkg::BR_DEC_NZ: return c.cmp_lhs != 8'h01;
			default: return 1'b0;
		endcase
	endfunction : branch_true

	// ****************************************
	// Address forming
	// ****************************************

	// Decoded opcode, shared with the address unit
	cpu_timing_pkg::decode_t dec;
	// Addresses formed from operand bytes
	cpu_timing_pkg::addr_out_t addr;

	assign dec = decode_op(opcode_i);

	operand_address_calc u_addr (
		.opcode_i(opcode_i),
		.op1_i(op1_i),
		.op2_i(op2_i),
		.len_i(dec.len),
		.next_pc_i(next_pc_i),
		.bank_i(bank_i),
		.addr_o(addr)
	);

	// ****************************************
	// Sequencer
	// ****************************************

	// Registered state and its next value
	cpu_timing_pkg::seq_t seq_reg;
	cpu_timing_pkg::seq_t seq_next;

	// Next-state logic
	always_comb begin
		logic tk;
		logic [3:0] n;
		logic [4:0] rd_sum;
		tk = 1'b0;
		n = `CYC_1;
		rd_sum = 5'h00;
		seq_next = seq_reg;
		seq_next.parity = ^cond_i.acc;
		// Strobes last one cycle
		seq_next.done = 1'b0;
		seq_next.bit_clear = 1'b0;
		seq_next.flash_write = 1'b0;
		seq_next.flash_erase = 1'b0;
		seq_next.ext = 1'b0;
		unique case (seq_reg.st)
			cpu_timing_pkg::ST_IDLE: begin
				if (start_i) begin
					tk = branch_true(dec.br, cond_i);
					n = dec.cyc;
					// code read, alignment and flash timing
					if (dec.code_rd) begin
						rd_sum = 5'(`CODE_RD_MIN) + 5'(code_rd_misaligned_i)
							+ 5'(flash_read_timing_field_i);
						n = (rd_sum > 5'(`CODE_RD_MAX)) ? `CODE_RD_MAX : rd_sum[3:0];
					end
					if (tk) begin
						n = n + `BRANCH_EXTRA;
					end
					// plain cycle count, no machine cycles
					seq_next.cycles = n;
					seq_next.remain = n - `CYC_1;
					seq_next.bytes = dec.len;
					seq_next.taken = tk;
					seq_next.tgt_valid = tk || (dec.br == cpu_timing_pkg::BR_NONE
						&& dec.tgt != cpu_timing_pkg::TGT_NONE);
					unique case (dec.tgt)
						cpu_timing_pkg::TGT_REL: seq_next.target = addr.rel_target;
						cpu_timing_pkg::TGT_ABS11: seq_next.target = addr.abs11_target;
						cpu_timing_pkg::TGT_ABS16: seq_next.target = addr.abs16_target;
						default: seq_next.target = next_pc_i;
					endcase
					seq_next.reg_addr = addr.reg_addr;
					seq_next.ind_addr = addr.ind_addr;
					seq_next.direct_addr = addr.direct_addr;
					seq_next.direct_is_sfr = addr.direct_is_sfr;
					seq_next.bit_clear = tk && (dec.br == cpu_timing_pkg::BR_BIT_CLR);
					seq_next.ext = dec.ext;
					seq_next.xwrite = dec.xwrite;
					seq_next.flash_write = dec.ext && dec.xwrite
						&& flash_write_enable_i && !flash_erase_enable_i;
					seq_next.flash_erase = dec.ext && dec.xwrite
						&& flash_write_enable_i && flash_erase_enable_i;
					seq_next.spare_nop = dec.spare;
					// counts hold only with prefetch on
					seq_next.timing_valid = prefetch_enable_bit_i;
					// end strobe in the last cycle
					if (n == `CYC_1) begin
						seq_next.done = 1'b1;
					end else begin
						seq_next.busy = 1'b1;
						seq_next.st = cpu_timing_pkg::ST_EXEC;
					end
				end
			end
			cpu_timing_pkg::ST_EXEC: begin
				// Count down the remaining cycles
				seq_next.remain = seq_reg.remain - `CYC_1;
				if (seq_reg.remain == `CYC_1) begin
					seq_next.done = 1'b1;
					seq_next.busy = 1'b0;
					seq_next.st = cpu_timing_pkg::ST_IDLE;
				end
			end
		endcase
	end

	// State register
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			seq_reg <= '{st: cpu_timing_pkg::ST_IDLE, default: '0};
		end else begin
			seq_reg <= seq_next;
		end
	end

	// ****************************************
	// Outputs straight from state
	// ****************************************
	assign busy_o = seq_reg.busy;
	assign end_o = seq_reg.done;
	assign cycle_count_o = seq_reg.cycles;
	assign byte_count_o = seq_reg.bytes;
	assign taken_o = seq_reg.taken;
	assign target_valid_o = seq_reg.tgt_valid;
	assign target_o = seq_reg.target;
	assign reg_addr_o = seq_reg.reg_addr;
	assign ind_addr_o = seq_reg.ind_addr;
	assign direct_addr_o = seq_reg.direct_addr;
	assign direct_is_sfr_o = seq_reg.direct_is_sfr;
	assign ext_access_o = seq_reg.ext;
	assign ext_write_o = seq_reg.xwrite;
	assign flash_write_o = seq_reg.flash_write;
	assign flash_erase_o = seq_reg.flash_erase;
	assign bit_clear_o = seq_reg.bit_clear;
	assign spare_nop_o = seq_reg.spare_nop;
	assign parity_o = seq_reg.parity;
	assign timing_valid_o = seq_reg.timing_valid;

endmodule : cpu_instruction_timing
`default_nettype wire

// [tb/code_mem_model.sv]
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// Program store feeding the fetch side
// ****************************************
module code_mem_model (
	input wire logic [15:0] pc_i,
	output logic [7:0] opcode_o,
	output logic [7:0] op1_o,
	output logic [7:0] op2_o
);
	// Only the low address byte is decoded, to keep the store small
	logic [7:0] mem [0:255];

	// Unwritten bytes hold a changing pattern, never a stale copy
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'(i) ^ 8'h5a;
		end
	end

	assign opcode_o = mem[pc_i[7:0]];
	assign op1_o = mem[pc_i[7:0] + 8'h01];
	assign op2_o = mem[pc_i[7:0] + 8'h02];
endmodule : code_mem_model

`default_nettype wire

// [tb/cpu_timing_checker.sv]
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// Port-level timing checks
// ****************************************
module cpu_timing_checker (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic start_i,
	input wire logic [7:0] opcode_i,
	input wire logic [7:0] op1_i,
	input wire logic [1:0] bank_i,
	input wire cpu_timing_pkg::cond_in_t cond_i,
	input wire logic busy_o,
	input wire logic end_o,
	input wire logic [3:0] cycle_count_o,
	input wire logic [1:0] byte_count_o,
	input wire logic taken_o,
	input wire logic [7:0] reg_addr_o,
	input wire logic [7:0] ind_addr_o,
	input wire logic [7:0] direct_addr_o,
	input wire logic direct_is_sfr_o,
	input wire logic ext_access_o,
	input wire logic spare_nop_o,
	input wire logic parity_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!resetn_i);

	// Start accepted at this edge (refused while busy)
	wire logic go = start_i && !busy_o;

	chk_spare_nop: assert property (go && opcode_i == 8'ha5 |=>
		end_o && spare_nop_o && cycle_count_o == 4'h1 && byte_count_o == 2'h1)
		else $error("spare opcode not a one-cycle no-op");
	chk_end_busy: assert property ($fell(busy_o) |-> end_o)
		else $error("busy dropped without end strobe");
	chk_reg_bank: assert property (go && opcode_i[3] |=>
		reg_addr_o == {3'h0, $past(bank_i), $past(opcode_i[2:0])})
		else $error("bank register address wrong");
	chk_ind_reg: assert property (go && opcode_i[3:1] == 3'h3 |=>
		ind_addr_o == {3'h0, $past(bank_i), 2'h0, $past(opcode_i[0])})
		else $error("indirect pointer register wrong");
	chk_direct_sfr: assert property (go |=>
		direct_addr_o == $past(op1_i) && direct_is_sfr_o == $past(op1_i[7]))
		else $error("direct address space split wrong");
	chk_parity_acc: assert property (1'b1 |=> parity_o == ^$past(cond_i.acc))
		else $error("parity does not follow accumulator");
	chk_ext_three: assert property (go && opcode_i inside {8'he2, 8'hf0, 8'hf3} |=>
		ext_access_o && !end_o ##1 !end_o ##1 end_o && cycle_count_o == 4'h3)
		else $error("external move not three cycles");
	chk_decbr_untaken: assert property (go && opcode_i[7:3] == 5'h1b && cond_i.cmp_lhs == 8'h01 |=>
		!end_o ##1 end_o && !taken_o && cycle_count_o == 4'h2)
		else $error("untaken decrement branch not two cycles");
	chk_decbr_taken: assert property (go && opcode_i[7:3] == 5'h1b && cond_i.cmp_lhs != 8'h01 |=>
		!end_o[*3] ##1 end_o && taken_o && cycle_count_o == 4'h4)
		else $error("taken decrement branch not four cycles");
endmodule : cpu_timing_checker

bind cpu_instruction_timing cpu_timing_checker u_chk (.core_clk_i, .resetn_i, .start_i,
	.opcode_i, .op1_i, .bank_i, .cond_i, .busy_o, .end_o, .cycle_count_o, .byte_count_o,
	.taken_o, .reg_addr_o, .ind_addr_o, .direct_addr_o, .direct_is_sfr_o, .ext_access_o,
	.spare_nop_o, .parity_o);

`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none

module tb_top;
	// ****************************************
	// Stimulus and observed signals
	// ****************************************
	logic core_clk_i, resetn_i, start_i, pf_on, mis, fwe, fee;
	logic [15:0] pc, next_pc;
	logic [1:0] bank, rd_tim;
	cpu_timing_pkg::cond_in_t cond;
	wire logic [7:0] opc, op1, op2;
	logic busy, endp, taken, tv, xa, xw, fw, fe, bc, sn, par, tval;
	logic [3:0] cyc;
	logic [1:0] nbytes;
	logic [15:0] tgt;
	int n_errors = 0;
	int tests_run = 0;
	// Opcodes covering every timing class under test
	logic [7:0] ops [0:18] = '{8'h28, 8'ha5, 8'h26, 8'he2, 8'hf0, 8'h43, 8'h90, 8'hb6,
		8'h10, 8'hd8, 8'h60, 8'h40, 8'h80, 8'h01, 8'h02, 8'h93, 8'h84, 8'ha4, 8'h22};

	// 125 MHz clock
	initial begin
		core_clk_i = 1'b0;
		forever #4 core_clk_i = ~core_clk_i;
	end

	code_mem_model u_mem (.pc_i(pc), .opcode_o(opc), .op1_o(op1), .op2_o(op2));

	cpu_instruction_timing uut (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
		.start_i(start_i), .opcode_i(opc), .op1_i(op1), .op2_i(op2), .next_pc_i(next_pc),
		.bank_i(bank), .cond_i(cond), .prefetch_enable_bit_i(pf_on),
		.flash_read_timing_field_i(rd_tim), .code_rd_misaligned_i(mis),
		.flash_write_enable_i(fwe), .flash_erase_enable_i(fee), .busy_o(busy), .end_o(endp),
		.cycle_count_o(cyc), .byte_count_o(nbytes), .taken_o(taken), .target_valid_o(tv),
		.target_o(tgt), .reg_addr_o(), .ind_addr_o(), .direct_addr_o(), .direct_is_sfr_o(),
		.ext_access_o(xa), .ext_write_o(xw), .flash_write_o(fw), .flash_erase_o(fe),
		.bit_clear_o(bc), .spare_nop_o(sn), .parity_o(par), .timing_valid_o(tval));

	// ****************************************
	// Expected values
	// ****************************************
	// Packed {length, base cycles}; code reads saturate at seven
	function automatic logic [5:0] exp_lc(input logic [7:0] op, input logic [1:0] fr,
		input logic m);
		logic [3:0] c;
		c = 4'h4 + {3'h0, m} + {2'h0, fr};
		case (op)
			8'h28, 8'ha5: return 6'h11;
			8'h26: return 6'h12;
			8'he2, 8'hf0: return 6'h13;
			8'h43, 8'h90, 8'h10: return 6'h33;
			8'hb6: return 6'h34;
			8'hd8, 8'h60, 8'h40: return 6'h22;
			8'h80, 8'h01, 8'ha4: return (op == 8'ha4) ? 6'h14 : 6'h24;
			8'h02: return 6'h35;
			8'h93: return {2'h1, (c > 4'h7) ? 4'h7 : c};
			8'h84: return 6'h18;
			default: return 6'h16;
		endcase
	endfunction : exp_lc

	// Branch condition per conditional opcode; others never count as taken
	function automatic logic br_taken(input logic [7:0] op, input cpu_timing_pkg::cond_in_t c);
		case (op)
			8'h10: return c.bit_val;
			8'hb6: return c.cmp_lhs != c.cmp_rhs;
			8'hd8: return c.cmp_lhs != 8'h01;
			8'h60: return c.acc == 8'h00;
			8'h40: return c.carry;
			default: return 1'b0;
		endcase
	endfunction : br_taken

	// Compare and count; unknowns match only unknowns
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic tally_and_finish();
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : tally_and_finish

	// ****************************************
	// One instruction, issued back to back
	// ****************************************
	task automatic run(input logic [7:0] op, input int rep);
		logic [5:0] lc;
		logic [3:0] n_exp;
		logic [7:0] b1, b2, last;
		logic [15:0] tg;
		logic tk, tvx, xa0, fw0, fe0, bcs;
		int n;
		pc = 16'($urandom);
		b1 = 8'($urandom);
		b2 = 8'($urandom);
		cond = 26'($urandom);
		{bank, rd_tim, mis, pf_on, fwe, fee} = 8'($urandom);
		// Corner operands: both outcomes of every branch condition
		if (rep == 0) cond = {8'h00, 1'b1, 1'b1, 8'h01, 8'h01};
		if (rep == 1) cond = {8'h05, 1'b0, 1'b0, 8'h02, 8'h03};
		u_mem.mem[pc[7:0]] = op;
		u_mem.mem[pc[7:0] + 8'h01] = b1;
		u_mem.mem[pc[7:0] + 8'h02] = b2;
		lc = exp_lc(op, rd_tim, mis);
		tk = br_taken(op, cond);
		n_exp = lc[3:0] + (tk ? 4'h2 : 4'h0);
		next_pc = pc + {14'h0, lc[5:4]};
		last = (lc[5:4] == 2'h3) ? b2 : b1;
		tg = next_pc + {{8{last[7]}}, last};
		if (op == 8'h01) tg = {next_pc[15:11], op[7:5], b1};
		if (op == 8'h02) tg = {b1, b2};
		tvx = tk || op inside {8'h80, 8'h01, 8'h02};
		start_i = 1'b1;
		@(posedge core_clk_i);
		#1;
		n = 1;
		// Start stays high: every busy edge must refuse it, and the next
		// call raises it again without a second write in one time step
		{xa0, fw0, fe0, bcs} = {xa, fw, fe, bc};
		while (endp !== 1'b1) begin
			if (n > 20) begin
				n_errors++;
				tally_and_finish();
			end
			@(posedge core_clk_i);
			#1;
			n++;
			bcs = bcs | bc;
		end
		chk("cycles", 16'(n), {12'h0, n_exp});
		chk("cycle_count", {12'h0, cyc}, {12'h0, n_exp});
		chk("bytes", {14'h0, nbytes}, {14'h0, lc[5:4]});
		chk("taken", taken, tk);
		chk("target_valid", tv, tvx);
		if (tvx) chk("target", tgt, tg);
		chk("ext_access", xa0, op inside {8'he2, 8'hf0});
		chk("ext_write", xw, op == 8'hf0);
		chk("flash_write", fw0, op == 8'hf0 && fwe && !fee);
		chk("flash_erase", fe0, op == 8'hf0 && fwe && fee);
		chk("bit_clear", bcs, op == 8'h10 && tk);
		chk("spare", sn, op == 8'ha5);
		chk("timing_valid", tval, pf_on);
		chk("busy", busy, 1'b0);
	endtask : run

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{resetn_i, start_i, pf_on, mis, fwe, fee, bank, rd_tim} = '0;
		{pc, next_pc, cond} = '0;
		void'($urandom(32'h3e84485b));
		repeat (20) @(posedge core_clk_i);
		#1;
		resetn_i = 1'b1;
		for (int r = 0; r < 4; r++) begin
			foreach (ops[i]) run(ops[i], r);
		end
		// Reset in mid-instruction, then resume
		start_i = 1'b1;
		@(posedge core_clk_i);
		#1;
		{start_i, resetn_i} = 2'b00;
		repeat (2) @(posedge core_clk_i);
		#1;
		resetn_i = 1'b1;
		chk("busy_after_reset", busy, 1'b0);
		foreach (ops[i]) run(ops[i], 2);
		tally_and_finish();
	end
endmodule : tb_top

`default_nettype wire
